// ===== hw/crf_pkg.sv
// Constants and carrier types for the CPU register file and flag word.
// Assumes a single 20 MHz clock and a datapath that sequences instructions.
package crf_pkg;
   localparam int ADDR_W         = 16;
   localparam int FETCH_W        = 24;
   localparam int GR_COUNT       = 8;
   localparam int GR_W           = 32;
   localparam int GR_SEL_W       = 3;
   localparam logic [2:0] STACK_REG = 3'h7;
   localparam int FLAG_MASK_BIT  = 7;
   localparam int FLAG_USR6_BIT  = 6;
   localparam int FLAG_HALF_BIT  = 5;
   localparam int FLAG_USR4_BIT  = 4;
   localparam int FLAG_SIGN_BIT  = 3;
   localparam int FLAG_ZERO_BIT  = 2;
   localparam int FLAG_OVF_BIT   = 1;
   localparam int FLAG_CARRY_BIT = 0;
   localparam int HALF_BIT_BYTE  = 4;
   localparam int HALF_BIT_WORD  = 12;
   localparam int HALF_BIT_LONG  = 28;
   localparam logic [7:0]  FLAG_RESET = 8'h80;
   localparam logic [23:0] FETCH_RESET = 24'h000000;

   typedef enum logic [1:0] {CRF_SZ_BYTE = 2'h0, CRF_SZ_WORD = 2'h1, CRF_SZ_LONG = 2'h2} crf_size_t;
   // Byte lane picks second_byte or bottom_byte, half picks upper or lower
   typedef enum logic [1:0] {CRF_PART_LOW = 2'h0, CRF_PART_HIGH = 2'h1} crf_part_t;
   typedef enum logic [2:0] {CRF_FOP_NONE = 3'h0, CRF_FOP_LOAD = 3'h1, CRF_FOP_AND = 3'h2,
                             CRF_FOP_OR = 3'h3, CRF_FOP_XOR = 3'h4} crf_fop_t;
   typedef enum logic [3:0] {CRF_CC_T = 4'h0, CRF_CC_F = 4'h1, CRF_CC_HI = 4'h2, CRF_CC_LS = 4'h3,
                             CRF_CC_CC = 4'h4, CRF_CC_CS = 4'h5, CRF_CC_NE = 4'h6, CRF_CC_EQ = 4'h7,
                             CRF_CC_VC = 4'h8, CRF_CC_VS = 4'h9, CRF_CC_PL = 4'hA, CRF_CC_MI = 4'hB,
                             CRF_CC_GE = 4'hC, CRF_CC_LT = 4'hD, CRF_CC_GT = 4'hE, CRF_CC_LE = 4'hF} crf_cond_t;
   typedef enum logic [2:0] {CRF_AR_ADD = 3'h0, CRF_AR_ADDX = 3'h1, CRF_AR_SUB = 3'h2,
                             CRF_AR_SUBX = 3'h3, CRF_AR_CMP = 3'h4, CRF_AR_NEG = 3'h5} crf_arith_t;
   // One-hot exception sequencer states
   typedef enum logic [2:0] {CRF_ST_RUN = 3'b001, CRF_ST_VEC = 3'b010, CRF_ST_EXC = 3'b100} crf_state_t;

   typedef struct packed {
      logic                wr_en;
      logic [GR_SEL_W-1:0] sel;
      crf_size_t           size;
      crf_part_t           part;
      logic [GR_W-1:0]     data;
   } crf_gr_wr_t;

   typedef struct packed {
      logic       valid;
      crf_arith_t op;
      crf_size_t  size;
      logic [GR_W-1:0] a;
      logic [GR_W-1:0] b;
      logic [7:0] upd_mask;
   } crf_arith_req_t;
endpackage

// ===== hw/crf_core.sv
// Register file, fetch counter and flag word of the CPU core.
// Assumes the datapath sequences instructions and supplies the reset vector word.
`timescale 1ns/1ps
module crf_core import crf_pkg::*; (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire crf_gr_wr_t           gr_wr,
   input  wire logic [GR_SEL_W-1:0]  rd_sel,
   input  wire crf_size_t            rd_size,
   input  wire crf_part_t            rd_part,
   input  wire logic                 sp_wr_en,
   input  wire logic [GR_W-1:0]      sp_wr_data,
   input  wire logic                 pc_load,
   input  wire logic [FETCH_W-1:0]   pc_load_val,
   input  wire logic                 pc_step,
   input  wire logic                 vec_valid,
   input  wire logic [ADDR_W-1:0]    vec_data,
   input  wire logic                 exc_start,
   input  wire crf_arith_req_t       arith,
   input  wire crf_fop_t             flag_op,
   input  wire logic [7:0]           flag_imm,
   input  wire logic [7:0]           flag_set_val,
   input  wire logic [7:0]           flag_set_mask,
   input  wire crf_cond_t            cond_sel,
   input  wire logic                 irq_maskable,
   input  wire logic                 unmaskable_request,
   output logic [GR_W-1:0]           rd_data_q,
   output logic [GR_W-1:0]           stack_top_ptr_q,
   output logic [ADDR_W-1:0]         fetch_addr_q,
   output logic [FETCH_W-1:0]        next_fetch_addr_q,
   output logic [7:0]                flag_word_q,
   output logic                      cond_true_q,
   output logic                      irq_accept_q,
   output logic                      reset_busy_q
);
   logic [GR_W-1:0]    gr_q [GR_COUNT];
   logic [7:0]         flag_d;
   logic [FETCH_W-1:0] pc_d;
   crf_state_t         state_q;
   logic               res_half;
   logic [GR_W-1:0]    res;
   logic               res_zero;
   logic               res_sign;
   logic               res_c;
   logic               res_v;
   logic [GR_W:0]      sum;
   logic [GR_W-1:0]    bx;
   logic [GR_W-1:0]    ax;
   logic               cin;
   logic               is_sub;
   logic [GR_W-1:0]    rd_mux;
   logic               cc;

   // fetch on 64 kbyte space, word aligned
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fetch_addr_q <= {FETCH_RESET[ADDR_W-1:1], 1'b0};
      end else begin
         fetch_addr_q <= {pc_d[ADDR_W-1:1], 1'b0};
      end
   end

   // register writes by size and lane, then stack writes from calls and exceptions
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < GR_COUNT; i++) begin
            gr_q[i] <= 32'h00000000;
         end
      end else begin
         if (gr_wr.wr_en) begin
            unique case (gr_wr.size)
               CRF_SZ_LONG: gr_q[gr_wr.sel] <= gr_wr.data;
               CRF_SZ_WORD: begin
                  if (gr_wr.part == CRF_PART_HIGH) begin
                     gr_q[gr_wr.sel][31:16] <= gr_wr.data[15:0];
                  end else begin
                     gr_q[gr_wr.sel][15:0] <= gr_wr.data[15:0];
                  end
               end
               default: begin
                  if (gr_wr.part == CRF_PART_HIGH) begin
                     gr_q[gr_wr.sel][15:8] <= gr_wr.data[7:0];
                  end else begin
                     gr_q[gr_wr.sel][7:0] <= gr_wr.data[7:0];
                  end
               end
            endcase
         end
         // Implicit stack update wins over an explicit write
         if (sp_wr_en) begin
            gr_q[STACK_REG] <= sp_wr_data;
         end
      end
   end

   // each read chooses its own width and lane
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (rd_size)
         CRF_SZ_LONG: rd_mux = gr_q[rd_sel];
         CRF_SZ_WORD: rd_mux = {16'h0000, (rd_part == CRF_PART_HIGH) ? gr_q[rd_sel][31:16] : gr_q[rd_sel][15:0]};
         default:     rd_mux = {24'h000000, (rd_part == CRF_PART_HIGH) ? gr_q[rd_sel][15:8] : gr_q[rd_sel][7:0]};
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_q       <= 32'h00000000;
         stack_top_ptr_q <= 32'h00000000;
      end else begin
         rd_data_q       <= rd_mux;
         stack_top_ptr_q <= sp_wr_en ? sp_wr_data : gr_q[STACK_REG];
      end
   end

   // Reset exception sequencer: wait for the vector word
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= CRF_ST_VEC;
      end else begin
         unique case (state_q)
            CRF_ST_VEC: begin
               if (vec_valid) begin
                  state_q <= CRF_ST_RUN;
               end
            end
            CRF_ST_EXC: state_q <= CRF_ST_RUN;
            CRF_ST_RUN: begin
               if (exc_start) begin
                  state_q <= CRF_ST_EXC;
               end
            end
            default:    state_q <= CRF_ST_VEC;
         endcase
      end
   end

   // Busy until the vector word has been taken
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reset_busy_q <= 1'b1;
      end else begin
         reset_busy_q <= (state_q == CRF_ST_VEC) && !vec_valid;
      end
   end

   // fetch counter and vector load
   // Jumps and steps offered before the vector arrives are dropped
   always_comb begin
      pc_d = next_fetch_addr_q;
      if (state_q == CRF_ST_VEC) begin
         if (vec_valid) begin
            pc_d = {8'h00, vec_data};
         end
      end else if (pc_load) begin
         pc_d = pc_load_val;
      end else if (pc_step) begin
         pc_d = next_fetch_addr_q + 24'h000002;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         next_fetch_addr_q <= FETCH_RESET;
      end else begin
         next_fetch_addr_q <= pc_d;
      end
   end

   // Arithmetic flag generation; adder shared by all sizes
   always_comb begin
      is_sub = (arith.op != CRF_AR_ADD) && (arith.op != CRF_AR_ADDX);
      // Negate adds to zero, so the carry terms must see zero as well
      ax     = (arith.op == CRF_AR_NEG) ? 32'h00000000 : arith.a;
      cin    = 1'b0;
      bx     = arith.b;
      if (arith.op == CRF_AR_ADDX) begin
         cin = flag_word_q[FLAG_CARRY_BIT];
      end
      if (is_sub) begin
         bx  = ~arith.b;
         cin = (arith.op == CRF_AR_SUBX) ? ~flag_word_q[FLAG_CARRY_BIT] : 1'b1;
      end
      sum = {1'b0, ax} + {1'b0, bx} + {32'h00000000, cin};
      res = sum[GR_W-1:0];
      unique case (arith.size)
         CRF_SZ_BYTE: begin
            res_half = sum[HALF_BIT_BYTE] ^ ax[HALF_BIT_BYTE] ^ bx[HALF_BIT_BYTE];
            res_c    = sum[8] ^ ax[8] ^ bx[8];
            res_zero = (res[7:0] == 8'h00);
            res_sign = res[7];
            res_v    = (ax[7] == bx[7]) && (res[7] != ax[7]);
         end
         CRF_SZ_WORD: begin
            res_half = sum[HALF_BIT_WORD] ^ ax[HALF_BIT_WORD] ^ bx[HALF_BIT_WORD];
            res_c    = sum[16] ^ ax[16] ^ bx[16];
            res_zero = (res[15:0] == 16'h0000);
            res_sign = res[15];
            res_v    = (ax[15] == bx[15]) && (res[15] != ax[15]);
         end
         default: begin
            res_half = sum[HALF_BIT_LONG] ^ ax[HALF_BIT_LONG] ^ bx[HALF_BIT_LONG];
            res_c    = sum[GR_W];
            res_zero = (res == 32'h00000000);
            res_sign = res[31];
            res_v    = (ax[31] == bx[31]) && (res[31] != ax[31]);
         end
      endcase
      // Subtraction flags report a borrow, the inverse of the adder carry
      if (is_sub) begin
         res_half = ~res_half;
         res_c    = ~res_c;
      end
   end

   // Flag word next value, exceptions last so the mask cannot be lost
   always_comb begin
      flag_d = flag_word_q;
      // only flags named in the mask change
      // zero and sign from the result
      if (arith.valid) begin
         if (arith.upd_mask[FLAG_HALF_BIT]) begin
            flag_d[FLAG_HALF_BIT] = res_half;
         end
         if (arith.upd_mask[FLAG_SIGN_BIT]) begin
            flag_d[FLAG_SIGN_BIT] = res_sign;
         end
         if (arith.upd_mask[FLAG_ZERO_BIT]) begin
            flag_d[FLAG_ZERO_BIT] = res_zero;
         end
         if (arith.upd_mask[FLAG_OVF_BIT]) begin
            flag_d[FLAG_OVF_BIT] = res_v;
         end
         if (arith.upd_mask[FLAG_CARRY_BIT]) begin
            flag_d[FLAG_CARRY_BIT] = res_c;
         end
      end
      // Other instructions hand over chosen flags directly
      flag_d = (flag_d & ~flag_set_mask) | (flag_set_val & flag_set_mask);
      // flag ops reach every bit, user bits included
      unique case (flag_op)
         CRF_FOP_LOAD: flag_d = flag_imm;
         CRF_FOP_AND:  flag_d = flag_word_q & flag_imm;
         CRF_FOP_OR:   flag_d = flag_word_q | flag_imm;
         CRF_FOP_XOR:  flag_d = flag_word_q ^ flag_imm;
         default:      flag_d = flag_d;
      endcase
      if (exc_start) begin
         flag_d[FLAG_MASK_BIT] = 1'b1;
      end
   end

   // reset sets only the mask bit
   // Other bits keep their value, so they stay unknown until software loads them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flag_word_q <= {1'b1, flag_word_q[FLAG_MASK_BIT-1:0]};
      end else begin
         flag_word_q <= flag_d;
      end
   end

   // branch conditions from sign, zero, overflow, carry
   always_comb begin
      unique case (cond_sel)
         CRF_CC_T:  cc = 1'b1;
         CRF_CC_F:  cc = 1'b0;
         CRF_CC_HI: cc = !(flag_word_q[FLAG_CARRY_BIT] | flag_word_q[FLAG_ZERO_BIT]);
         CRF_CC_LS: cc = flag_word_q[FLAG_CARRY_BIT] | flag_word_q[FLAG_ZERO_BIT];
         CRF_CC_CC: cc = !flag_word_q[FLAG_CARRY_BIT];
         CRF_CC_CS: cc = flag_word_q[FLAG_CARRY_BIT];
         CRF_CC_NE: cc = !flag_word_q[FLAG_ZERO_BIT];
         CRF_CC_EQ: cc = flag_word_q[FLAG_ZERO_BIT];
         CRF_CC_VC: cc = !flag_word_q[FLAG_OVF_BIT];
         CRF_CC_VS: cc = flag_word_q[FLAG_OVF_BIT];
         CRF_CC_PL: cc = !flag_word_q[FLAG_SIGN_BIT];
         CRF_CC_MI: cc = flag_word_q[FLAG_SIGN_BIT];
         CRF_CC_GE: cc = !(flag_word_q[FLAG_SIGN_BIT] ^ flag_word_q[FLAG_OVF_BIT]);
         CRF_CC_LT: cc = flag_word_q[FLAG_SIGN_BIT] ^ flag_word_q[FLAG_OVF_BIT];
         CRF_CC_GT: cc = !(flag_word_q[FLAG_ZERO_BIT] | (flag_word_q[FLAG_SIGN_BIT] ^ flag_word_q[FLAG_OVF_BIT]));
         CRF_CC_LE: cc = flag_word_q[FLAG_ZERO_BIT] | (flag_word_q[FLAG_SIGN_BIT] ^ flag_word_q[FLAG_OVF_BIT]);
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cond_true_q <= 1'b0;
      end else begin
         cond_true_q <= cc;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_accept_q <= 1'b0;
      end else begin
         irq_accept_q <= (state_q == CRF_ST_RUN) &&
                         (unmaskable_request || (irq_maskable && !flag_word_q[FLAG_MASK_BIT]));
      end
   end
endmodule // crf_core

// ===== verification/crf_core_properties.sv
// Concurrent checks on the fetch counter, flag word and interrupt ports.
// Assumes one sys_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module crf_core_properties import crf_pkg::*; (
   input wire logic                sys_clk,
   input wire logic                rst,
   input wire crf_arith_req_t      arith,
   input wire crf_fop_t            flag_op,
   input wire logic [7:0]          flag_imm,
   input wire logic [7:0]          flag_set_mask,
   input wire logic                exc_start,
   input wire logic                irq_maskable,
   input wire logic                unmaskable_request,
   input wire logic                vec_valid,
   input wire logic [ADDR_W-1:0]   vec_data,
   input wire logic                pc_step,
   input wire logic                pc_load,
   input wire logic [FETCH_W-1:0]  pc_load_val,
   input wire logic [ADDR_W-1:0]   fetch_addr_q,
   input wire logic [FETCH_W-1:0]  next_fetch_addr_q,
   input wire logic [7:0]          flag_word_q,
   input wire logic                irq_accept_q,
   input wire logic                reset_busy_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_fetch_even_copy: assert property (fetch_addr_q == (next_fetch_addr_q[15:0] & 16'hFFFE))
      else $error("fetch address is not the even copy of the counter");
   a_vector_load: assert property (reset_busy_q && vec_valid
      |=> !reset_busy_q && next_fetch_addr_q == {8'h00, $past(vec_data)}) else $error("vector word not loaded");
   a_busy_hold: assert property (reset_busy_q && !vec_valid
      |=> reset_busy_q && $stable(next_fetch_addr_q)) else $error("counter moved before vector");
   a_pc_step: assert property (!reset_busy_q && pc_step && !pc_load
      |=> next_fetch_addr_q == $past(next_fetch_addr_q) + 24'h000002) else $error("counter step wrong");
   a_pc_jump: assert property (!reset_busy_q && pc_load
      |=> next_fetch_addr_q == $past(pc_load_val)) else $error("counter jump wrong");
   a_exc_mask: assert property (exc_start && !arith.valid && flag_set_mask == 8'h00 && flag_op == CRF_FOP_NONE
      |=> flag_word_q[7]) else $error("exception entry left mask clear");
   a_mask_blocks: assert property (irq_maskable && !unmaskable_request && flag_word_q[7]
      && flag_op == CRF_FOP_NONE |=> !irq_accept_q) else $error("masked request accepted");
   a_nmi_taken: assert property (unmaskable_request && !reset_busy_q && !$past(exc_start)
      |=> irq_accept_q) else $error("unmaskable request refused");
   a_flag_xor: assert property (flag_op == CRF_FOP_XOR && !arith.valid && flag_set_mask == 8'h00 && !exc_start
      |=> flag_word_q == ($past(flag_word_q) ^ $past(flag_imm))) else $error("flag xor result wrong");
   c_vector: cover property (reset_busy_q && vec_valid);
   c_nmi: cover property (unmaskable_request && flag_word_q[7]);
   c_exc: cover property (exc_start);
endmodule // crf_core_properties

// ===== verification/tb_crf_core.sv
// Self-checking bench for the register file, fetch counter and flag word.
// Drives crf_core directly; no partner model stands beside it.
`timescale 1ns/1ps
module tb_crf_core import crf_pkg::*; ;
   logic                sys_clk = 1'b0;
   logic                rst = 1'b1;
   crf_gr_wr_t          gr_wr = '0;
   logic [2:0]          rd_sel = '0;
   crf_size_t           rd_size = CRF_SZ_BYTE;
   crf_part_t           rd_part = CRF_PART_LOW;
   logic                sp_wr_en = 1'b0, pc_load = 1'b0, pc_step = 1'b0, vec_valid = 1'b0, exc_start = 1'b0;
   logic                irq_maskable = 1'b0, unmaskable_request = 1'b0, cond_true_q, irq_accept_q, reset_busy_q;
   logic [31:0]         sp_wr_data = '0, rd_data_q, stack_top_ptr_q;
   logic [23:0]         pc_load_val = '0, next_fetch_addr_q, pc;
   logic [15:0]         vec_data = '0, fetch_addr_q;
   crf_arith_req_t      arith = '0;
   crf_fop_t            flag_op = CRF_FOP_NONE;
   logic [7:0]          flag_imm = '0, flag_set_val = '0, flag_set_mask = '0, flag_word_q, f;
   crf_cond_t           cond_sel = CRF_CC_T;
   logic [31:0]         m [8];
   crf_arith_t          ops [6] = '{CRF_AR_ADD, CRF_AR_ADDX, CRF_AR_SUB, CRF_AR_SUBX, CRF_AR_CMP, CRF_AR_NEG};
   int                  miscompares = 0, total_checks = 0;

   crf_core DUT (.*);
   always #25 sys_clk = ~sys_clk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Design takes the request, then all strobes drop together
   task automatic fin();
      @(posedge sys_clk);
      {gr_wr.wr_en, arith.valid, flag_set_mask, irq_maskable, unmaskable_request, exc_start, vec_valid, pc_step,
       pc_load, sp_wr_en} <= '0;
      flag_op <= CRF_FOP_NONE;
      @(negedge sys_clk);
   endtask

   function automatic logic [31:0] put(logic [31:0] r, crf_size_t s, crf_part_t p, logic [31:0] d);
      if (s == CRF_SZ_LONG) return d;
      if (s == CRF_SZ_WORD) return p == CRF_PART_HIGH ? {d[15:0], r[15:0]} : {r[31:16], d[15:0]};
      return p == CRF_PART_HIGH ? {r[31:16], d[7:0], r[7:0]} : {r[31:8], d[7:0]};
   endfunction

   function automatic logic [31:0] get(logic [31:0] r, crf_size_t s, crf_part_t p);
      if (s == CRF_SZ_LONG) return r;
      if (s == CRF_SZ_WORD) return p == CRF_PART_HIGH ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
      return p == CRF_PART_HIGH ? {24'h000000, r[15:8]} : {24'h000000, r[7:0]};
   endfunction

   task automatic fop(input crf_fop_t op, input logic [7:0] imm);
      @(posedge sys_clk);
      flag_op <= op;
      flag_imm <= imm;
      fin();
      case (op)
         CRF_FOP_LOAD: f = imm;
         CRF_FOP_AND: f = f & imm;
         CRF_FOP_OR: f = f | imm;
         default: f = f ^ imm;
      endcase
      chk(flag_word_q, f);
   endtask

   task automatic irq(input logic mk, input logic um, input logic exp);
      @(posedge sys_clk);
      irq_maskable <= mk;
      unmaskable_request <= um;
      fin();
      chk(irq_accept_q, exp);
   endtask

   initial begin : main
      logic [31:0] d, a, b, x;
      logic [63:0] lm, mm, ci, cy, res, h;
      logic [7:0]  msk;
      logic        e, ad;
      int          s, p, r, n;
      crf_arith_t  o;
      void'($urandom(32'hC06FFBE3));
      for (int i = 0; i < 8; i++) m[i] = 32'h00000000;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk(reset_busy_q, 1'b1);
      chk(flag_word_q[7], 1'b1);
      // Step offered in vector state must be ignored
      d = $urandom();
      @(posedge sys_clk);
      vec_valid <= 1'b1;
      vec_data <= d[15:0] | 16'h0001;
      pc_step <= 1'b1;
      fin();
      pc = {8'h00, d[15:0] | 16'h0001};
      chk(next_fetch_addr_q, pc);
      chk(reset_busy_q, 1'b0);
      for (int i = 0; i < 6; i++) begin
         d = $urandom();
         @(posedge sys_clk);
         pc_step <= 1'b1;
         pc_load <= d[0];
         pc_load_val <= d[31:8];
         fin();
         pc = d[0] ? d[31:8] : pc + 24'h000002;
         chk(next_fetch_addr_q, pc);
         chk(fetch_addr_q, pc[15:0] & 16'hFFFE);
      end
      for (int i = 0; i < 60; i++) begin
         d = $urandom();
         r = $urandom_range(7);
         s = $urandom_range(2);
         p = $urandom_range(1);
         @(posedge sys_clk);
         if (i % 5 == 4) begin
            sp_wr_en <= 1'b1;
            sp_wr_data <= d;
            m[7] = d;
         end else begin
            gr_wr <= '{1'b1, r[2:0], crf_size_t'(s), crf_part_t'(p), d};
            m[r] = put(m[r], crf_size_t'(s), crf_part_t'(p), d);
         end
         fin();
         r = $urandom_range(7);
         s = $urandom_range(2);
         p = $urandom_range(1);
         @(posedge sys_clk);
         rd_sel <= r[2:0];
         rd_size <= crf_size_t'(s);
         rd_part <= crf_part_t'(p);
         @(posedge sys_clk);
         @(negedge sys_clk);
         chk(rd_data_q, get(m[r], crf_size_t'(s), crf_part_t'(p)));
         // Stack output lags a plain register write by one cycle
         chk(stack_top_ptr_q, m[7]);
      end
      for (int i = 1; i < 5; i++) fop(crf_fop_t'(i), 8'($urandom()));
      for (int c = 0; c < 16; c++) begin
         fop(CRF_FOP_LOAD, 8'($urandom()));
         @(posedge sys_clk);
         cond_sel <= crf_cond_t'(c);
         @(posedge sys_clk);
         @(negedge sys_clk);
         // Even codes test the plain condition, odd codes its inverse
         case (c / 2)
            0: e = 1'b1;
            1: e = !(f[0] | f[2]);
            2: e = !f[0];
            3: e = !f[2];
            4: e = !f[1];
            5: e = !f[3];
            6: e = !(f[3] ^ f[1]);
            default: e = !(f[2] | (f[3] ^ f[1]));
         endcase
         chk(cond_true_q, e ^ c[0]);
      end
      // Every op at every size; some with an empty update mask
      for (int k = 0; k < 18; k++) begin
         fop(CRF_FOP_LOAD, 8'($urandom()));
         s = k % 3;
         o = ops[k / 3];
         a = $urandom();
         b = $urandom();
         msk = (k % 5 == 4) ? 8'h00 : 8'h2F;
         n = 8 << s;
         lm = (64'h1 << (n - 4)) - 64'h1;
         mm = (64'h1 << n) - 64'h1;
         ad = (o == CRF_AR_ADD) || (o == CRF_AR_ADDX);
         ci = (o == CRF_AR_ADDX || o == CRF_AR_SUBX) ? {63'h0, f[0]} : 64'h0;
         x = (o == CRF_AR_NEG) ? 32'h00000000 : a;
         res = ad ? {32'h0, x} + {32'h0, b} + ci : {32'h0, x} - {32'h0, b} - ci;
         h = ad ? (((x & lm) + (b & lm) + ci) >> (n - 4)) : 64'((x & lm) < (b & lm) + ci);
         cy = ad ? (((x & mm) + (b & mm) + ci) >> n) : 64'((x & mm) < (b & mm) + ci);
         @(posedge sys_clk);
         arith <= '{1'b1, o, crf_size_t'(s), a, b, msk};
         fin();
         if (msk != 8'h00) begin
            f[5] = h[0];
            f[3] = res[n-1];
            f[2] = (res & mm) == 64'h0;
            f[1] = (ad ? (x[n-1] == b[n-1]) : (x[n-1] != b[n-1])) && (res[n-1] != x[n-1]);
            f[0] = cy[0];
         end
         chk(flag_word_q, f);
      end
      fop(CRF_FOP_LOAD, 8'h00);
      irq(1'b1, 1'b0, 1'b1);
      irq(1'b0, 1'b1, 1'b1);
      fop(CRF_FOP_LOAD, 8'h80);
      irq(1'b1, 1'b0, 1'b0);
      irq(1'b1, 1'b1, 1'b1);
      fop(CRF_FOP_LOAD, 8'h00);
      @(posedge sys_clk);
      exc_start <= 1'b1;
      fin();
      f[7] = 1'b1;
      chk(flag_word_q, f);
      @(posedge sys_clk);
      flag_set_mask <= 8'h50;
      flag_set_val <= 8'h50;
      fin();
      chk(flag_word_q, f | 8'h50);
      complete_run();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      complete_run();
   end
endmodule // tb_crf_core

bind crf_core crf_core_properties CHK (.sys_clk, .rst, .arith, .flag_op, .flag_imm, .flag_set_mask, .exc_start,
   .irq_maskable, .unmaskable_request, .vec_valid, .vec_data, .pc_step, .pc_load, .pc_load_val, .fetch_addr_q,
   .next_fetch_addr_q, .flag_word_q, .irq_accept_q, .reset_busy_q);
